/* rtl/tlf_temp_protect.sv */
// tlf_temp_protect: temperature limits, over-temperature fault response and status flags.
// assumes an Avalon-MM master with byte addresses and temperatures in 1/16 degree signed.
// Summary of operation
// - action code 10 disables output on over-temperature fault, then applies retry setting
// - configured fault pulls alert low and sets sticky flag until clear-faults
// - retry 000: output stays disabled until fault cleared
// - continuous retry restarts forever unless commanded off, bias lost, other fault
// - retry codes 001-110 unused; bits 2:0 read 111; retry wait 210 ms
// - action byte resets to 80h, read/write, write protected
// - overheat warning sets summary, warning bit, sensor flag, alerts host
// - any enabled sensor, internal or remote, can raise a warning
// - cold warning sets summary, cold warning bit, sensor flag, alerts host
// - cold fault sets summary, cold fault bit, sensor flag, alerts host
// - thresholds are linear-11: Y times 2 to the N
// - overheat warning threshold resets to EB70h, +110 C
// - cold warning threshold resets to DC40h, -30 C
// - cold fault threshold resets to E530h, -45 C
// - all limits readable, writable and honour write protection
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module tlf_temp_protect
    import tlf_pkg::*;
#(
    parameter int RETRY_DELAY_CYCLES = RETRY_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] internal_temperature,
    input wire logic [15:0] remote_temperature_input0,
    input wire logic [15:0] remote_temperature_input1,
    input wire logic [2:0] overheat_fault_detect,
    input wire logic control_pin_on,
    input wire logic bias_power_good,
    input wire logic other_fault_shutdown,
    output logic power_disable,
    output logic alert_output_n
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] overheat_fault_action;
    logic [15:0] overheat_warning_threshold;
    logic [15:0] cold_warning_threshold;
    logic [15:0] cold_fault_threshold;
    logic [7:0] ctrl;
    logic [7:0] wrprot;
    logic [7:0] flags;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_DOWN = 3'b010,
        ST_WAIT = 3'b100
    } tlf_state_t;
    tlf_state_t state;
    tlf_state_t next_state;

    tlf_retry_if rif ();

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire logic [7:0] index = avs_address[9:2];
    wire logic aligned = (avs_address[1:0] == 2'b00);
    wire logic wr_go = avs_write && !avs_waitrequest && aligned;
    wire logic protect = wrprot[WP_BIT];
    wire logic wr_open = wr_go && !protect;
    wire logic wr_action = wr_open && (index == IDX_OT_ACTION) && avs_byteenable[0];
    wire logic wr_otw = wr_open && (index == IDX_OT_WARN);
    wire logic wr_cw = wr_open && (index == IDX_COLD_WARN);
    wire logic wr_cf = wr_open && (index == IDX_COLD_FAULT);
    wire logic wr_ctrl = wr_open && (index == IDX_CTRL) && avs_byteenable[0];
    wire logic wr_wp = wr_go && (index == IDX_WRPROT) && avs_byteenable[0];
    wire logic clear_faults = wr_go && (index == IDX_CLEAR);

    // merge a 16-bit register with the written lanes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////////
    // action byte fields; unused retry codes behave as no retry
    wire logic [1:0] resp_code = overheat_fault_action[RESP_HI:RESP_LO];
    wire logic [2:0] retry_code = overheat_fault_action[RETRY_HI:RETRY_LO];
    wire logic resp_disable = (resp_code == RESP_DISABLE);
    wire logic retry_cont = (retry_code == RETRY_CONT);
    wire logic run_allowed = ctrl[CTRL_RUN_BIT] && control_pin_on && bias_power_good && !other_fault_shutdown;

    ////////////////////////////////////////////////////////////////////////////
    // thresholds to fixed point
    wire logic [15:0] thr_word [0:2];
    logic signed [31:0] thr_fix [0:2];
    assign thr_word[0] = overheat_warning_threshold;
    assign thr_word[1] = cold_warning_threshold;
    assign thr_word[2] = cold_fault_threshold;

    genvar gt;
    generate
        for (gt = 0; gt < 3; gt++) begin : g_thr
            tlf_lin11_to_fix #(.FRAC(TEMP_FRAC)) u_conv (
                .lin(thr_word[gt]),
                .value(thr_fix[gt])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // per-sensor comparisons; remote sensors count only when enabled
    wire logic [15:0] temp [0:NSENSE-1];
    wire logic [NSENSE-1:0] sensor_on = {ctrl[1:0], 1'b1};
    logic [NSENSE-1:0] otw_hit;
    logic [NSENSE-1:0] cw_hit;
    logic [NSENSE-1:0] cf_hit;
    logic [NSENSE-1:0] otf_hit;
    assign temp[0] = internal_temperature;
    assign temp[1] = remote_temperature_input0;
    assign temp[2] = remote_temperature_input1;

    genvar gs;
    generate
        for (gs = 0; gs < NSENSE; gs++) begin : g_sense
            wire logic signed [31:0] t_fix = {{16{temp[gs][15]}}, temp[gs]};
            assign otw_hit[gs] = sensor_on[gs] && (t_fix >= thr_fix[0]);
            assign cw_hit[gs] = sensor_on[gs] && (t_fix <= thr_fix[1]);
            assign cf_hit[gs] = sensor_on[gs] && (t_fix <= thr_fix[2]);
            assign otf_hit[gs] = sensor_on[gs] && overheat_fault_detect[gs] && resp_disable;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags; a new event in the clearing cycle survives
    wire logic ot_fault_now = |otf_hit;
    wire logic [NSENSE-1:0] sensor_ev = otw_hit | cw_hit | cf_hit | otf_hit;
    wire logic any_ev = |sensor_ev;
    logic [7:0] set_mask;
    always_comb begin
        set_mask = 8'h00;
        set_mask[ST_SUMMARY] = any_ev;
        set_mask[ST_COLD_FAULT] = |cf_hit;
        set_mask[ST_COLD_WARN] = |cw_hit;
        set_mask[ST_OT_WARN] = |otw_hit;
        set_mask[ST_OT_FAULT] = ot_fault_now;
        set_mask[ST_SENSOR+NSENSE-1:ST_SENSOR] = sensor_ev;
    end
    wire logic [7:0] next_flags = (clear_faults ? 8'h00 : flags) | set_mask;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= 8'h00;
            alert_output_n <= 1'b1;
        end else begin
            flags <= next_flags;
            alert_output_n <= ~(|next_flags);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault response sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (ot_fault_now) begin
                    next_state = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (retry_cont && run_allowed) begin
                    next_state = ST_WAIT;
                end else if (clear_faults && !ot_fault_now) begin
                    next_state = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (!run_allowed) begin
                    next_state = ST_DOWN;
                end else if (rif.expired && !ot_fault_now) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_DOWN;
        endcase
    end

    // restart the delay on entry to waiting and after every failed attempt
    assign rif.start = ((state == ST_DOWN) && (next_state == ST_WAIT))
        || ((state == ST_WAIT) && rif.expired && ot_fault_now && run_allowed);

    tlf_retry_timer #(.CYCLES(RETRY_DELAY_CYCLES)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .rif(rif)
    );

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RUN;
            power_disable <= 1'b0;
        end else begin
            state <= next_state;
            power_disable <= (next_state != ST_RUN) || !run_allowed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overheat_fault_action <= RST_OT_ACTION;
            overheat_warning_threshold <= RST_OT_WARN;
            cold_warning_threshold <= RST_COLD_WARN;
            cold_fault_threshold <= RST_COLD_FAULT;
            ctrl <= RST_CTRL;
            wrprot <= RST_WRPROT;
        end else begin
            if (wr_action) overheat_fault_action <= avs_writedata[7:0];
            if (wr_otw) overheat_warning_threshold <= merge16(overheat_warning_threshold, avs_writedata, avs_byteenable);
            if (wr_cw) cold_warning_threshold <= merge16(cold_warning_threshold, avs_writedata, avs_byteenable);
            if (wr_cf) cold_fault_threshold <= merge16(cold_fault_threshold, avs_writedata, avs_byteenable);
            if (wr_ctrl) ctrl <= avs_writedata[7:0];
            if (wr_wp) wrprot <= avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; bits 2:0 of the action byte always read 111, unmapped reads zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (aligned) begin
            unique case (index)
                IDX_OT_ACTION: rd_mux[7:0] = {overheat_fault_action[7:3], ACTION_PAD};
                IDX_OT_WARN: rd_mux[15:0] = overheat_warning_threshold;
                IDX_COLD_WARN: rd_mux[15:0] = cold_warning_threshold;
                IDX_COLD_FAULT: rd_mux[15:0] = cold_fault_threshold;
                IDX_CTRL: rd_mux[7:0] = ctrl;
                IDX_WRPROT: rd_mux[7:0] = wrprot;
                IDX_STATUS: rd_mux[ST_DISABLED:0] = {power_disable, flags};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // one wait state per access: waitrequest drops for exactly one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) avs_readdata <= rd_mux;
        end
    end
endmodule : tlf_temp_protect
`default_nettype wire

/* rtl/tlf_pkg.sv */
// tlf_pkg: constants for the temperature limit and fault response block.
// assumes a 40 MHz clock and 32-bit Avalon-MM register words, byte address = 4 * index.
package tlf_pkg;
    // register indices
    localparam logic [7:0] IDX_CTRL = 8'h01;
    localparam logic [7:0] IDX_CLEAR = 8'h03;
    localparam logic [7:0] IDX_WRPROT = 8'h10;
    localparam logic [7:0] IDX_OT_ACTION = 8'h50;
    localparam logic [7:0] IDX_OT_WARN = 8'h51;
    localparam logic [7:0] IDX_COLD_WARN = 8'h52;
    localparam logic [7:0] IDX_COLD_FAULT = 8'h53;
    localparam logic [7:0] IDX_STATUS = 8'h7d;
    // reset values
    localparam logic [7:0] RST_OT_ACTION = 8'h80;
    localparam logic [15:0] RST_OT_WARN = 16'heb70;
    localparam logic [15:0] RST_COLD_WARN = 16'hdc40;
    localparam logic [15:0] RST_COLD_FAULT = 16'he530;
    localparam logic [7:0] RST_CTRL = 8'h80;
    localparam logic [7:0] RST_WRPROT = 8'h00;
    // fault action byte layout
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [1:0] RESP_DISABLE = 2'b10;
    localparam logic [2:0] RETRY_NONE = 3'b000;
    localparam logic [2:0] RETRY_CONT = 3'b111;
    localparam logic [2:0] ACTION_PAD = 3'b111;
    // control and protect bits
    localparam int CTRL_RUN_BIT = 7;
    localparam int WP_BIT = 7;
    // status bit positions
    localparam int ST_SUMMARY = 0;
    localparam int ST_COLD_FAULT = 1;
    localparam int ST_COLD_WARN = 2;
    localparam int ST_OT_WARN = 3;
    localparam int ST_OT_FAULT = 4;
    localparam int ST_SENSOR = 5;
    localparam int ST_DISABLED = 8;
    // linear-11 fields, sensor count and fixed-point fraction bits
    localparam int EXP_LO = 11;
    localparam int NSENSE = 3;
    localparam int TEMP_FRAC = 4;
    // retry delay
    localparam int RETRY_DELAY_MS = 210;
    localparam int CLK_HZ = 40_000_000;
    localparam int RETRY_CYCLES = RETRY_DELAY_MS * (CLK_HZ / 1000);
endpackage : tlf_pkg

/* rtl/tlf_retry_if.sv */
// tlf_retry_if: start/expire handshake between the response sequencer and its delay timer.
// assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface tlf_retry_if;
    logic start;
    logic expired;
    modport seq (output start, input expired);
    modport tmr (input start, output expired);
endinterface : tlf_retry_if
`default_nettype wire

/* rtl/tlf_lin11_to_fix.sv */
// tlf_lin11_to_fix: converts a linear-11 word into signed fixed point with FRAC fraction bits.
// assumes FRAC is small enough that the result fits in 32 bits.
`timescale 1ns/1ps
`default_nettype none
module tlf_lin11_to_fix
    import tlf_pkg::*;
#(
    parameter int FRAC = TEMP_FRAC
) (
    input wire logic [15:0] lin,
    output logic signed [31:0] value
);
    wire logic signed [4:0] expo = lin[15:EXP_LO];
    wire logic signed [31:0] mant = {{21{lin[EXP_LO-1]}}, lin[EXP_LO-1:0]};
    wire logic signed [6:0] shift = 7'(expo) + 7'(FRAC);
    wire logic [5:0] lsh = shift[5:0];
    wire logic [5:0] rsh = 6'(-shift);

    // value = Y * 2^N; right shifts floor toward minus infinity, a sixteenth of a degree at most
    assign value = shift[6] ? (mant >>> rsh) : (mant <<< lsh);
endmodule : tlf_lin11_to_fix
`default_nettype wire

/* rtl/tlf_retry_timer.sv */
// tlf_retry_timer: one-shot delay between restart attempts.
// assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module tlf_retry_timer
    import tlf_pkg::*;
#(
    parameter int CYCLES = RETRY_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    tlf_retry_if.tmr rif
);
    logic [23:0] count;
    logic running;

    // count down, pulse expired on the last cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 24'h000000;
            running <= 1'b0;
            rif.expired <= 1'b0;
        end else begin
            rif.expired <= running && (count == 24'h000001);
            if (rif.start) begin
                count <= 24'(CYCLES);
                running <= 1'b1;
            end else if (running) begin
                count <= count - 24'h000001;
                running <= (count != 24'h000001);
            end
        end
    end
endmodule : tlf_retry_timer
`default_nettype wire

/* tb/tlf_temp_protect_monitor.sv */
// tlf_temp_protect_monitor: port-level checks of the temperature protection block.
// assumes it is bound to tlf_temp_protect; one clock, active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tlf_temp_protect_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [2:0] overheat_fault_detect,
    input wire logic control_pin_on,
    input wire logic bias_power_good,
    input wire logic other_fault_shutdown,
    input wire logic power_disable,
    input wire logic alert_output_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // bus answer: one wait cycle, waitrequest low for one cycle only
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait cycle");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // misaligned reads give zero; the action byte pads bits 2:0 with ones
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
        else $error("misaligned read not zero");
    pad_bits_a: assert property (avs_read && !avs_waitrequest && avs_address == 10'h140 |-> avs_readdata[31:8] == 24'h0 && avs_readdata[2:0] == 3'b111)
        else $error("action byte padding wrong");
    ////////////////////////////////////////////////////////////////
    // flags are sticky: only a completed write (clear) may lift the alert
    alert_hold_a: assert property (!alert_output_n && !(avs_write && !avs_waitrequest) |=> !alert_output_n)
        else $error("alert released without clear");
    // a shutdown while run is allowed must come with the alert
    trip_alert_a: assert property ($rose(power_disable) && $past(control_pin_on) && $past(bias_power_good) && !$past(other_fault_shutdown) |-> !alert_output_n)
        else $error("fault shutdown without alert");
    off_cmd_a: assert property (!control_pin_on || !bias_power_good || other_fault_shutdown |=> power_disable)
        else $error("output not disabled when commanded off");
    restart_cause_a: assert property ($fell(power_disable) |-> $past(overheat_fault_detect) == 3'b000 && $past(control_pin_on))
        else $error("restart with fault present or commanded off");
    cover property (avs_read && !avs_waitrequest);
    cover property ($rose(power_disable));
    cover property ($fell(power_disable) && alert_output_n == 1'b0);
endmodule : tlf_temp_protect_monitor
`default_nettype wire

/* tb/tlf_host_model.sv */
// tlf_host_model: management host issuing register cycles on the Avalon-MM port.
// assumes the device answers with waitrequest; a cycle gives up after 40 clocks.
`timescale 1ns/1ps
`default_nettype none
module tlf_host_model (
    input wire logic clk,
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 10'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    ////////////////////////////////////////////////////////////////
    // one cycle: an idle edge first so back-to-back calls never double-drive
    task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                        output logic ok);
        int n;
        ok = 1'b0;
        q = 32'h0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        for (n = 0; n < 40 && !ok; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                ok = 1'b1;
                q = avs_readdata;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
endmodule : tlf_host_model
`default_nettype wire

/* tb/tb_top.sv */
// tb_top: self-checking bench for tlf_temp_protect with a host model on the register bus.
// assumes a shortened retry delay of 20 cycles; temperatures in 1/16 degree units.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tlf_pkg::*;
    localparam int DLY = 20;
    localparam logic [15:0] IDLE = 16'h0190;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, control_pin_on, bias_power_good;
    logic other_fault_shutdown, power_disable, alert_output_n;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable;
    logic [15:0] internal_temperature, remote_temperature_input0, remote_temperature_input1;
    logic [2:0] overheat_fault_detect;
    int failures, checks, n, i;
    tlf_host_model u_tlf_host_model (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    tlf_temp_protect #(.RETRY_DELAY_CYCLES(DLY)) u_tlf_temp_protect (.clk(clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .internal_temperature(internal_temperature), .remote_temperature_input0(remote_temperature_input0),
        .remote_temperature_input1(remote_temperature_input1), .overheat_fault_detect(overheat_fault_detect),
        .control_pin_on(control_pin_on), .bias_power_good(bias_power_good),
        .other_fault_shutdown(other_fault_shutdown), .power_disable(power_disable), .alert_output_n(alert_output_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    // shared helpers; a hung wait ends the run through wrap_up
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
        logic ok;
        u_tlf_host_model.xfer({idx, 2'b00}, w, d, q, ok);
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t bus cycle hung", $time);
            wrap_up();
        end
    endtask : bus
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
        bus(idx, 1'b0, 32'h0);
        chk(q, exp, what);
    endtask : rd_chk
    task automatic wait_pd(input logic v);
        for (n = 0; n < 200 && power_disable !== v; n++) @(posedge clk);
        if (power_disable !== v) begin
            failures++;
            $display("[ERR] %0t power_disable stuck", $time);
            wrap_up();
        end
    endtask : wait_pd
    task automatic temps(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        internal_temperature <= a;
        remote_temperature_input0 <= b;
        remote_temperature_input1 <= c;
    endtask : temps
    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs;
        rd_chk(IDX_OT_ACTION, 32'h87, "action reset");
        rd_chk(IDX_OT_WARN, 32'heb70, "warn reset");
        rd_chk(IDX_COLD_WARN, 32'hdc40, "cold warn reset");
        rd_chk(IDX_COLD_FAULT, 32'he530, "cold fault reset");
        bus(IDX_COLD_WARN, 1'b1, 32'h0000dc41); // stays inside the legal cold range
        rd_chk(IDX_COLD_WARN, 32'hdc41, "cold warn write");
        bus(IDX_WRPROT, 1'b1, 32'h80);
        bus(IDX_COLD_WARN, 1'b1, 32'h0000dc40);
        bus(IDX_OT_ACTION, 1'b1, 32'h0);
        rd_chk(IDX_COLD_WARN, 32'hdc41, "protected limit");
        rd_chk(IDX_OT_ACTION, 32'h87, "protected action");
        bus(IDX_WRPROT, 1'b1, 32'h0);
        bus(IDX_COLD_WARN, 1'b1, 32'h0000dc40);
        rd_chk(8'hff, 32'h0, "unmapped read");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_warn;
        bus(IDX_CTRL, 1'b1, 32'h83);
        temps(16'h06df, IDLE, IDLE);
        rd_chk(IDX_STATUS, 32'h0, "below limit");
        for (i = 0; i < 3; i++) begin
            temps(i == 0 ? 16'h06e0 : IDLE, i == 1 ? 16'h06e0 : IDLE, i == 2 ? 16'h06e0 : IDLE);
            rd_chk(IDX_STATUS, 32'h09 | (32'h20 << i), "overheat warn");
            chk({31'h0, alert_output_n}, 32'h0, "alert low");
            temps(IDLE, IDLE, IDLE);
            bus(IDX_CLEAR, 1'b1, 32'h0);
            rd_chk(IDX_STATUS, 32'h0, "flags cleared");
        end
        temps(16'hfe20, IDLE, IDLE);
        rd_chk(IDX_STATUS, 32'h25, "cold warn");
        temps(16'hfd30, IDLE, IDLE);
        rd_chk(IDX_STATUS, 32'h27, "cold fault");
        temps(IDLE, IDLE, IDLE);
        bus(IDX_OT_WARN, 1'b1, 32'h00000032); // 50 C with exponent 0
        temps(16'h0320, IDLE, IDLE);
        rd_chk(IDX_STATUS, 32'h2f, "linear-11 limit");
        temps(IDLE, IDLE, IDLE);
        bus(IDX_OT_WARN, 1'b1, 32'h0000eb70);
        bus(IDX_CLEAR, 1'b1, 32'h0);
        $display("t_warn done");
    endtask : t_warn
    task automatic t_latch;
        for (i = 0; i < 5; i++) begin
            bus(IDX_OT_ACTION, 1'b1, i == 0 ? 32'h80 : i == 1 ? 32'h88 : i == 2 ? 32'h00 : i == 3 ? 32'h40 : 32'hc0);
            overheat_fault_detect <= 3'b001;
            repeat (3 * DLY) @(posedge clk);
            overheat_fault_detect <= 3'b000;
            repeat (3 * DLY) @(posedge clk);
            chk({31'h0, power_disable}, i < 2 ? 32'h1 : 32'h0, "fault shutdown held");
            bus(IDX_STATUS, 1'b0, 32'h0);
            chk(q & 32'h110, i < 2 ? 32'h110 : 32'h0, "fault flag");
            bus(IDX_CLEAR, 1'b1, 32'h0);
            wait_pd(1'b0);
        end
        $display("t_latch done");
    endtask : t_latch
    task automatic t_retry;
        bus(IDX_OT_ACTION, 1'b1, 32'hb8); // a careful host avoids this pairing
        overheat_fault_detect <= 3'b010;
        wait_pd(1'b1);
        repeat (3 * DLY) @(posedge clk);
        chk({31'h0, power_disable}, 32'h1, "retry blocked by fault");
        overheat_fault_detect <= 3'b000;
        wait_pd(1'b0);
        chk({31'h0, n >= 1 && n <= DLY + 2}, 32'h1, "retry delay");
        for (i = 0; i < 3; i++) begin
            control_pin_on <= i != 0;
            bias_power_good <= i != 1;
            other_fault_shutdown <= i == 2;
            repeat (3) @(posedge clk);
            chk({31'h0, power_disable}, 32'h1, "commanded off");
            control_pin_on <= 1'b1;
            bias_power_good <= 1'b1;
            other_fault_shutdown <= 1'b0;
            bus(IDX_CLEAR, 1'b1, 32'h0);
            wait_pd(1'b0);
        end
        $display("t_retry done");
    endtask : t_retry
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        failures = 0;
        checks = 0;
        rstn = 1'b0;
        control_pin_on = 1'b1;
        bias_power_good = 1'b1;
        other_fault_shutdown = 1'b0;
        overheat_fault_detect = 3'b000;
        internal_temperature = IDLE;
        remote_temperature_input0 = IDLE;
        remote_temperature_input1 = IDLE;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_warn();
        t_latch();
        t_retry();
        wrap_up();
    end
endmodule : tb_top
bind tlf_temp_protect tlf_temp_protect_monitor u_tlf_temp_protect_monitor (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .overheat_fault_detect(overheat_fault_detect),
    .control_pin_on(control_pin_on), .bias_power_good(bias_power_good), .other_fault_shutdown(other_fault_shutdown),
    .power_disable(power_disable), .alert_output_n(alert_output_n));
`default_nettype wire
